// ---- hw/acs_cfg.svh ----
// constants for the conversion sequencer: fields, reset values, timing
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_CONV_NORMAL 5'd13
`define ACS_CONV_FIRST 5'd25
`define ACS_SAMPLE_NORMAL 5'd3
`define ACS_SAMPLE_FIRST 5'd16
`define ACS_SAMPLE_AUTO 5'd2
`define ACS_TRIG_SYNC 2'd3
`define ACS_CHAN_RESET 2'h0
`define ACS_RESULT_RESET 8'h00
`define ACS_TS_FREE 3'h0
`define ACS_MAX_DIV_LOG 7
`endif

// ---- hw/acs_pkg.sv ----
// types for the conversion sequencer
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_WAIT_EDGE,
    ACS_CONVERT
  } acs_state_e;
endpackage

// ---- hw/acs_prescaler.sv ----
// converter clock prescaler giving one-cycle enable pulses
`timescale 1ns/10ps
`include "acs_cfg.svh"
module acs_prescaler (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic [2:0] divide_sel,
  // converter clock enable
  output logic tick
);
  typedef struct packed {
    logic [6:0] count;
  } acs_presc_s;
  acs_presc_s st_r;
  acs_presc_s st_nxt;
  logic [6:0] limit;
  // ratio 2 for codes 0 and 1, else two to the code
  always_comb begin
    if (divide_sel == 3'h0) begin
      limit = 7'h01;
    end else begin
      limit = 7'((8'h01 << divide_sel) - 8'h01);
    end
  end
  // held in reset while disabled; restarted by an auto trigger
  always_comb begin
    st_nxt = st_r;
    tick = 1'b0;
    if (!run || restart) begin
      st_nxt.count = 7'h00;
    end else if (st_r.count >= limit) begin
      st_nxt.count = 7'h00;
      tick = 1'b1;
    end else begin
      st_nxt.count = st_r.count + 7'h01;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- hw/acs_edge_sync.sv ----
// trigger edge detector with a short synchronising pipeline
`timescale 1ns/10ps
`include "acs_cfg.svh"
module acs_edge_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // trigger level in
  input wire logic level,
  // rising edge pulse after the sync delay
  output logic rise
);
  typedef struct packed {
    logic [2:0] pipe;
    logic last;
  } acs_sync_s;
  acs_sync_s st_r;
  acs_sync_s st_nxt;
  // three cycles of delay, then edge compare on settled stages
  always_comb begin
    st_nxt = st_r;
    st_nxt.pipe = {st_r.pipe[1:0], level};
    st_nxt.last = st_r.pipe[2];
    rise = st_r.pipe[2] & ~st_r.last;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- hw/acs_sequencer.sv ----
// conversion start, timing and channel control for an 8-bit sar converter
// Overview of operation
// R1: start bit launches, stays high, self-clears
// R2: channel change waits for running conversion
// R3: auto trigger enable with source select
// R4: trigger edge restarts prescaler, starts conversion
// R5: edges during conversion and held levels ignored
// R6: source flag must clear before next trigger
// R7: completion flag source runs free after start
// R8: start write works with auto trigger
// R9: prescaler runs only while enabled
// R10: software keeps converter clock 50-200 kHz
// R11: start on next converter clock edge
// R12: 13 cycles normal, 25 after enable
// R13: sample at 3, first at 16
// R14: end: result, flag, clear start
// R15: auto sample 2 cycles after edge
// R16: half-cycle sample offsets follow timing; the code samples on whole converter cycles (3, 16 and 2)
// R17: free run restarts immediately, start high
// R18: channel follows buffer except while converting
// R19: software waits a cycle before channel write
// R20: software changes channel only safely
// R21: free run channel change lags one result
// R22: disable aborts; writing zero ignored
// R23: channel codes 00 to 11 pick inputs
// R24: start with or after enable is long
// R25: flag sticky until vector or one written
`timescale 1ns/10ps
`include "acs_cfg.svh"
module acs_sequencer (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control bits
  input wire logic converter_power_reduce,
  input wire logic converter_enable,
  input wire logic auto_trigger_enable,
  input wire logic [2:0] trigger_source_select,
  input wire logic [2:0] clock_divide_select,
  // start bit write
  input wire logic conv_start_write,
  input wire logic conv_start_wdata,
  // completion flag clear
  input wire logic flag_write,
  input wire logic flag_wdata,
  input wire logic irq_vector_taken,
  // channel select buffer write
  input wire logic channel_write,
  input wire logic [1:0] channel_wdata,
  // trigger sources other than free run, one per code
  input wire logic [7:0] trigger_sources,
  // conversion core
  input wire logic [7:0] core_result,
  output logic [1:0] channel_select_field,
  output logic [3:0] input_enable,
  output logic sample_hold,
  output logic core_active,
  // status
  output logic conv_start_bit,
  output logic conv_complete_flag,
  output logic [7:0] conv_result_reg,
  output logic [1:0] channel_select_reg
);
  typedef struct packed {
    acs_pkg::acs_state_e state;
    logic start_bit;
    logic flag;
    logic first;
    logic auto_conv;
    logic [4:0] cycle;
    logic [1:0] chan_buf;
    logic [1:0] chan_live;
    logic [7:0] result;
    logic sample;
  } acs_seq_s;
  acs_seq_s st_r;
  acs_seq_s st_nxt;
  logic tick;
  logic trig_rise;
  logic trig_level;
  logic restart;
  logic start_req;
  logic trig_start;
  logic [4:0] conv_len;
  logic [4:0] samp_at;
  logic active;

  assign active = converter_enable & ~converter_power_reduce;

  // selected trigger level; flag only matters in its free run role
  always_comb begin
    trig_level = trigger_sources[trigger_source_select]; // R3
  end

  // the source's own flag must drop before its next edge can count
  acs_edge_sync u_sync (
    .clock(clock),
    .rst(rst),
    .level(trig_level),
    .rise(trig_rise)
  ); // R6

  // edge only honoured when idle; held high never retriggers
  assign trig_start = active & auto_trigger_enable & trig_rise
    & (trigger_source_select != `ACS_TS_FREE)
    & (st_r.state == acs_pkg::ACS_IDLE); // R4 R5
  assign restart = trig_start; // R4

  acs_prescaler u_presc (
    .clock(clock),
    .rst(rst),
    .run(active),
    .restart(restart),
    .divide_sel(clock_divide_select),
    .tick(tick)
  ); // R9

  // writes of zero to the start bit do nothing
  assign start_req = conv_start_write & conv_start_wdata; // R22 R8

  // length and sample point by kind of conversion
  always_comb begin
    if (st_r.first) begin
      conv_len = `ACS_CONV_FIRST; // R12 R24
      samp_at = `ACS_SAMPLE_FIRST; // R13
    end else if (st_r.auto_conv) begin
      conv_len = `ACS_CONV_NORMAL;
      samp_at = `ACS_SAMPLE_AUTO; // R15 R16
    end else begin
      conv_len = `ACS_CONV_NORMAL; // R12
      samp_at = `ACS_SAMPLE_NORMAL; // R13 R16
    end
  end

  // main sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.sample = 1'b0;
    if (channel_write) begin
      st_nxt.chan_buf = channel_wdata;
    end
    // flag: vector or write-one clears, completion below wins
    if (irq_vector_taken || (flag_write && flag_wdata)) begin
      st_nxt.flag = 1'b0; // R25
    end
    // live channel follows buffer outside the locked window
    if (st_r.state != acs_pkg::ACS_CONVERT) begin
      st_nxt.chan_live = st_r.chan_buf; // R18 R2
    end
    case (st_r.state)
      acs_pkg::ACS_IDLE: begin
        if (start_req && active) begin
          st_nxt.start_bit = 1'b1; // R1
          st_nxt.auto_conv = 1'b0;
          st_nxt.state = acs_pkg::ACS_WAIT_EDGE; // R11
        end else if (trig_start) begin
          st_nxt.start_bit = 1'b1; // R8
          st_nxt.auto_conv = 1'b1;
          st_nxt.state = acs_pkg::ACS_WAIT_EDGE;
        end
      end
      acs_pkg::ACS_WAIT_EDGE: begin
        if (tick) begin
          st_nxt.cycle = 5'h00;
          st_nxt.chan_live = st_r.chan_buf; // R18
          st_nxt.state = acs_pkg::ACS_CONVERT; // R11
        end
      end
      acs_pkg::ACS_CONVERT: begin
        if (tick) begin
          st_nxt.cycle = st_r.cycle + 5'h01;
          if (st_r.cycle + 5'h01 == samp_at) begin
            st_nxt.sample = 1'b1; // R13 R15
          end
          // unlock during the last converter cycle
          if (st_r.cycle + 5'h02 >= conv_len) begin
            st_nxt.chan_live = st_r.chan_buf; // R18 R21
          end
          if (st_r.cycle + 5'h01 == conv_len) begin
            st_nxt.result = core_result; // R14
            st_nxt.flag = 1'b1; // R14
            st_nxt.first = 1'b0;
            st_nxt.auto_conv = 1'b0;
            st_nxt.cycle = 5'h00;
            if (auto_trigger_enable &&
                trigger_source_select == `ACS_TS_FREE) begin
              // free run: straight into the next one
              st_nxt.state = acs_pkg::ACS_CONVERT; // R7 R17
              st_nxt.chan_live = st_r.chan_buf; // R21
            end else begin
              st_nxt.start_bit = 1'b0; // R14 R1
              st_nxt.state = acs_pkg::ACS_IDLE;
            end
          end
        end
      end
      default: begin
        st_nxt.state = acs_pkg::ACS_IDLE;
      end
    endcase
    // disabling aborts and arms the long first conversion
    if (!active) begin
      st_nxt.state = acs_pkg::ACS_IDLE; // R22
      st_nxt.start_bit = 1'b0;
      st_nxt.first = 1'b1; // R24
      st_nxt.cycle = 5'h00;
      st_nxt.auto_conv = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r.state <= acs_pkg::ACS_IDLE;
      st_r.start_bit <= 1'b0;
      st_r.flag <= 1'b0;
      st_r.first <= 1'b1;
      st_r.auto_conv <= 1'b0;
      st_r.cycle <= 5'h00;
      st_r.chan_buf <= `ACS_CHAN_RESET;
      st_r.chan_live <= `ACS_CHAN_RESET;
      st_r.result <= `ACS_RESULT_RESET;
      st_r.sample <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs; channel decode one-hot to the mux
  assign channel_select_field = st_r.chan_live;
  assign input_enable = active ? (4'h1 << st_r.chan_live) : 4'h0; // R23
  assign sample_hold = st_r.sample;
  assign core_active = (st_r.state == acs_pkg::ACS_CONVERT);
  assign conv_start_bit = st_r.start_bit; // R8
  assign conv_complete_flag = st_r.flag;
  assign conv_result_reg = st_r.result;
  assign channel_select_reg = st_r.chan_buf;
endmodule

// ---- verif/acs_core_model.sv ----
// behavioural conversion core that samples the live channel
`timescale 1ns/10ps
module acs_core_model (
  // clock
  input wire logic clock,
  // from the sequencer
  input wire logic [1:0] channel_select_field,
  input wire logic sample_hold,
  // result back
  output logic [7:0] core_result
);
  // the code names its channel, so a late mux switch shows up
  always_ff @(posedge clock) begin
    if (sample_hold) begin
      core_result <= {6'h28, channel_select_field};
    end
  end
endmodule

// ---- verif/acs_monitor.sv ----
// checker bound to the conversion sequencer ports
`timescale 1ns/10ps
module acs_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // controls
  input wire logic converter_power_reduce,
  input wire logic converter_enable,
  input wire logic auto_trigger_enable,
  input wire logic conv_start_write,
  input wire logic conv_start_wdata,
  input wire logic flag_write,
  input wire logic flag_wdata,
  input wire logic irq_vector_taken,
  // outputs
  input wire logic [1:0] channel_select_field,
  input wire logic [3:0] input_enable,
  input wire logic sample_hold,
  input wire logic core_active,
  input wire logic conv_start_bit,
  input wire logic conv_complete_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // usable only when enabled and powered
  wire live = converter_enable && !converter_power_reduce;
  start_set_a: assert property (
    conv_start_write && conv_start_wdata && live && !conv_start_bit
    |=> conv_start_bit) else $error("start lost");
  zero_write_a: assert property (
    conv_start_write && !conv_start_wdata && !auto_trigger_enable
    && !conv_start_bit |=> !conv_start_bit) else $error("zero write");
  abort_off_a: assert property (
    !converter_enable |=> !conv_start_bit && !core_active)
    else $error("no abort");
  end_flag_a: assert property (
    $fell(conv_start_bit) && live |-> conv_complete_flag)
    else $error("no flag");
  hold_chan_a: assert property (
    sample_hold |-> $stable(channel_select_field)) else $error("chan moved");
  busy_start_a: assert property (
    core_active |-> conv_start_bit) else $error("start low");
  flag_keep_a: assert property (
    conv_complete_flag && !(flag_write && flag_wdata) && !irq_vector_taken
    |=> conv_complete_flag) else $error("flag lost");
  onehot_mux_a: assert property (
    live ? ($onehot(input_enable) && input_enable[channel_select_field])
    : (input_enable == 4'h0))
    else $error("bad enable");
  cover property ($fell(conv_start_bit));
  cover property (sample_hold && auto_trigger_enable);
  cover property ($rose(conv_complete_flag) && conv_start_bit);
endmodule
bind acs_sequencer acs_monitor i_mon (.*);

// ---- verif/acs_sequencer_test.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module acs_sequencer_test;
  // signals named as the ports
  logic clock, rst, converter_power_reduce, converter_enable;
  logic auto_trigger_enable, conv_start_write, conv_start_wdata;
  logic flag_write, flag_wdata, irq_vector_taken, channel_write;
  logic sample_hold, core_active, conv_start_bit, conv_complete_flag;
  logic [2:0] trigger_source_select, clock_divide_select;
  logic [1:0] channel_wdata, channel_select_field, channel_select_reg;
  logic [3:0] input_enable;
  logic [7:0] trigger_sources, core_result, conv_result_reg;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  acs_sequencer i_dut (.*);
  acs_core_model i_core (.*);
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  // one-cycle strobe from a falling edge; data is set by the caller
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // bounded wait for the completion flag
  task automatic done;
    n = 0;
    while (conv_complete_flag !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(conv_complete_flag, 8'h01);
  endtask
  task automatic t_single;
    channel_wdata = 2'h2;
    pulse(channel_write);
    cyc(1);
    chk(channel_select_field, 8'h02);
    chk(input_enable, 8'h04);
    chk(channel_select_reg, 8'h02);
    pulse(conv_start_write);
    chk(conv_start_bit, 8'h01);
    cyc(2);
    channel_wdata = 2'h3;
    pulse(channel_write);
    done;
    chk(n > 41 && n < 52, 8'h01);
    chk(conv_result_reg, 8'ha2);
    chk(conv_start_bit, 8'h00);
    chk(channel_select_field, 8'h03);
    pulse(irq_vector_taken);
    chk(conv_complete_flag, 8'h00);
    pulse(conv_start_write);
    done;
    chk(n > 22 && n < 30, 8'h01);
    chk(conv_result_reg, 8'ha3);
    $display("single conversions finished");
  endtask
  task automatic t_flag;
    flag_wdata = 1'b0;
    conv_start_wdata = 1'b0;
    pulse(flag_write);
    chk(conv_complete_flag, 8'h01);
    pulse(conv_start_write);
    chk(conv_start_bit, 8'h00);
    flag_wdata = 1'b1;
    conv_start_wdata = 1'b1;
    pulse(flag_write);
    chk(conv_complete_flag, 8'h00);
    $display("flag and zero writes finished");
  endtask
  task automatic t_trig;
    auto_trigger_enable = 1'b1;
    trigger_source_select = 3'h1;
    trigger_sources = 8'h02;
    // edge lands off the old tick phase, so a missed restart shows
    cyc(10);
    chk(sample_hold, 8'h01);
    chk(core_active, 8'h01);
    chk(conv_start_bit, 8'h01);
    trigger_sources = 8'h00;
    cyc(2);
    trigger_sources = 8'h02;
    done;
    chk(n, 8'h14);
    pulse(flag_write);
    cyc(60);
    chk(conv_complete_flag, 8'h00);
    chk(conv_start_bit, 8'h00);
    $display("auto trigger finished");
  endtask
  task automatic t_free;
    trigger_source_select = 3'h0;
    pulse(conv_start_write);
    done;
    // safe point: after a result, before its flag is cleared
    channel_wdata = 2'h2;
    pulse(channel_write);
    pulse(flag_write);
    done;
    chk(n < 30, 8'h01);
    chk(conv_start_bit, 8'h01);
    chk(conv_result_reg, 8'ha3);
    pulse(flag_write);
    done;
    chk(conv_result_reg, 8'ha2);
    converter_enable = 1'b0;
    cyc(1);
    chk(conv_start_bit, 8'h00);
    chk(input_enable, 8'h00);
    // power reduction blocks a start even while enabled
    converter_power_reduce = 1'b1;
    converter_enable = 1'b1;
    pulse(conv_start_write);
    chk(conv_start_bit, 8'h00);
    $display("free run finished");
  endtask
  task automatic t_div;
    // start just after power returns: long first one at ratio 8
    converter_power_reduce = 1'b0;
    auto_trigger_enable = 1'b0;
    clock_divide_select = 3'h3;
    pulse(flag_write);
    pulse(conv_start_write);
    done;
    chk(n > 199 && n < 212, 8'h01);
    $display("divided clock finished");
  endtask
  initial begin
    rst = 1'b1;
    {converter_power_reduce, converter_enable, auto_trigger_enable} = 3'h0;
    {conv_start_write, flag_write, irq_vector_taken, channel_write} = 4'h0;
    {conv_start_wdata, flag_wdata, channel_wdata} = 4'hc;
    // fast ratio keeps runs short; real parts need a slower rate
    {trigger_source_select, clock_divide_select} = 6'h00;
    trigger_sources = 8'h00;
    // count rising edges so a time-zero clock change cannot cut reset
    repeat (2) @(posedge clock);
    cyc(1);
    rst = 1'b0;
    converter_enable = 1'b1;
    cyc(1);
    t_single;
    t_flag;
    t_trig;
    t_free;
    t_div;
    tally_and_finish;
  end
  // watchdog far beyond the roughly 480 cycles the tests need
  initial begin
    #50000;
    miscompares++;
    tally_and_finish;
  end
endmodule
